// ### common/pdmc_pkg.sv
// pdmc_pkg: constants for the parity dram / prom memory controller.
// assumes a 250 MHz core clock; all timing counts derive from it.
package pdmc_pkg;
  localparam int CLK_PERIOD_NS = 4;
  localparam int PROM_TOP_ADDR = 16'h0800;     // first address past the prom
  localparam int ROW_BITS = 7;
  localparam int COL_BITS = 7;
  localparam int ROW_LSB = 0;
  localparam int COL_LSB = 7;
  localparam int ROWS = 128;
  localparam logic [7:0] BAD_PARITY_PORT = 8'h71;
  localparam logic [15:0] NMI_VECTOR = 16'h0066;
  // dram timing in ns
  localparam int T_ROW_HOLD_NS = 20;
  localparam int T_RAS_CAS_MAX_NS = 50;
  localparam int T_CAS_LOW_NS = 100;
  localparam int T_PRECHARGE_NS = 100;
  localparam int T_REFRESH_NS = 15600;
  localparam int T_RAS_ONLY_NS = 150;
  // least times round up, longest rounds down, all at least one cycle
  localparam int ROW_HOLD_CYC = (T_ROW_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RAS_CAS_MAX_CYC = T_RAS_CAS_MAX_NS / CLK_PERIOD_NS;
  localparam int CAS_LOW_CYC = (T_CAS_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PRECHARGE_CYC = (T_PRECHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REFRESH_CYC = T_REFRESH_NS / CLK_PERIOD_NS;
  localparam int RAS_ONLY_CYC = (T_RAS_ONLY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 12;
endpackage : pdmc_pkg

// ### hw/pdmc_parity.sv
`timescale 1ns/1ps
// pdmc_parity: even-parity bit for one byte, with forced-bad option.
// assumes purely combinational use inside the controller.
module pdmc_parity (
  input wire logic [7:0] data_i,
  input wire logic force_bad_i,
  output logic par_o
);
  // odd count of ones gives 1, making nine bits even; forcing sets 1 always
  assign par_o = (^data_i) | force_bad_i;
endmodule : pdmc_parity

// ### hw/pdmc_ctrl.sv
`timescale 1ns/1ps
// pdmc_ctrl: memory subsystem; address decode, prom select, dram ras/cas
// sequencing, refresh, parity generate/check, nmi and host interrupt.
// assumes a single requester port (cpu and dma arbitrated upstream),
// req_i held until ack_o; dram and prom data inputs are asynchronous pins.

module pdmc_ctrl
  import pdmc_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic req_i,
  input wire logic we_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic ack_o,
  output logic [7:0] rdata_o,
  input wire logic io_wr_i,
  input wire logic [7:0] io_port_i,
  input wire logic [7:0] io_wdata_i,
  input wire logic nmi_ack_i,
  output logic nmi_n_o,
  output logic [15:0] nmi_vector_o,
  output logic host_irq_o,
  input wire logic host_irq_clr_i,
  output logic [ROW_BITS-1:0] dram_addr_o,
  output logic dram_ras_n_o,
  output logic dram_cas_n_o,
  output logic dram_we_n_o,
  output logic [8:0] dram_d_o,
  input wire logic [8:0] dram_q_i,
  output logic [10:0] prom_addr_o,
  output logic prom_ce_n_o,
  input wire logic [7:0] prom_q_i
);
  typedef enum logic [2:0] {
    PDMC_IDLE, PDMC_ROW, PDMC_CAS, PDMC_PROM, PDMC_REF, PDMC_PRE
  } pdmc_state_t;

  typedef struct packed {
    pdmc_state_t st;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] ref_cnt;
    logic ref_due;
    logic [ROW_BITS-1:0] ref_row;
    logic [ROW_BITS-1:0] addr;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [8:0] dout;
    logic [7:0] rdata;
    logic ack;
    logic force_bad;
    logic nmi;
    logic irq;
    logic [8:0] q_s1;
    logic [8:0] q_s2;
    logic [7:0] p_s1;
    logic [7:0] p_s2;
  } pdmc_regs_t;

  pdmc_regs_t r, nxt;
  logic wpar;

  pdmc_parity u_par (
    .data_i(wdata_i),
    .force_bad_i(r.force_bad),
    .par_o(wpar)
  );

  always_comb begin
    nxt = r;
    nxt.ack = 1'b0;
    // pin inputs pass two flops before use
    nxt.q_s1 = dram_q_i;
    nxt.q_s2 = r.q_s1;
    nxt.p_s1 = prom_q_i;
    nxt.p_s2 = r.p_s1;
    // bad-parity mode armed by any write to the port; value ignored
    if (io_wr_i && io_port_i == BAD_PARITY_PORT) begin
      nxt.force_bad = 1'b1;
    end
    // refresh timer; due flag set wins against its own clear below
    if (r.ref_cnt == CNT_W'(REFRESH_CYC - 1)) begin
      nxt.ref_cnt = '0;
    end else begin
      nxt.ref_cnt = r.ref_cnt + 1'b1;
    end
    if (nmi_ack_i) begin
      nxt.nmi = 1'b0;
    end
    if (host_irq_clr_i) begin
      nxt.irq = 1'b0;
    end
    case (r.st)
      PDMC_IDLE: begin
        nxt.cnt = '0;
        if (r.ref_due) begin
          // refresh goes ahead of pending accesses so no row starves
          nxt.ref_due = 1'b0;
          nxt.addr = r.ref_row;
          nxt.ras_n = 1'b0;
          nxt.st = PDMC_REF;
        end else if (req_i && addr_i < 16'(PROM_TOP_ADDR)) begin
          nxt.st = PDMC_PROM;
        end else if (req_i) begin
          // row on the lines one cycle before row strobe falls
          nxt.addr = addr_i[ROW_LSB +: ROW_BITS];
          nxt.we_n = ~we_i;
          nxt.dout = {wpar, wdata_i};
          nxt.st = PDMC_ROW;
        end
      end
      PDMC_ROW: begin
        nxt.ras_n = 1'b0;
        nxt.cnt = r.cnt + 1'b1;
        // hold row, then switch to column well inside the ras-to-cas limit
        if (!r.ras_n && r.cnt >= CNT_W'(ROW_HOLD_CYC)) begin
          nxt.addr = addr_i[COL_LSB +: COL_BITS];
          nxt.cas_n = 1'b0;
          nxt.cnt = '0;
          nxt.st = PDMC_CAS;
        end
      end
      PDMC_CAS: begin
        nxt.cnt = r.cnt + 1'b1;
        if (r.cnt == CNT_W'(CAS_LOW_CYC - 1)) begin
          nxt.ras_n = 1'b1;
          nxt.cas_n = 1'b1;
          nxt.we_n = 1'b1;
          nxt.ack = 1'b1;
          nxt.rdata = r.q_s2[7:0];
          // nine-bit even parity: any odd count is an error
          if (r.we_n && (^r.q_s2)) begin
            nxt.nmi = 1'b1;
            nxt.irq = 1'b1;
          end
          nxt.cnt = '0;
          nxt.st = PDMC_PRE;
        end
      end
      PDMC_PROM: begin
        nxt.cnt = r.cnt + 1'b1;
        if (r.cnt == CNT_W'(CAS_LOW_CYC - 1)) begin
          nxt.rdata = r.p_s2;
          nxt.ack = 1'b1;
          nxt.cnt = '0;
          nxt.st = PDMC_PRE;
        end
      end
      PDMC_REF: begin
        nxt.cnt = r.cnt + 1'b1;
        if (r.cnt == CNT_W'(RAS_ONLY_CYC - 1)) begin
          nxt.ras_n = 1'b1;
          nxt.ref_row = r.ref_row + 1'b1;
          nxt.cnt = '0;
          nxt.st = PDMC_PRE;
        end
      end
      PDMC_PRE: begin
        nxt.cnt = r.cnt + 1'b1;
        if (r.cnt == CNT_W'(PRECHARGE_CYC - 1)) begin
          nxt.cnt = '0;
          nxt.st = PDMC_IDLE;
        end
      end
      default: begin
        nxt.st = PDMC_IDLE;
      end
    endcase
    if (r.ref_cnt == CNT_W'(REFRESH_CYC - 1)) begin
      nxt.ref_due = 1'b1;
    end
    if (io_wr_i && io_port_i == BAD_PARITY_PORT) begin
      nxt.force_bad = 1'b1;
    end else if (r.st == PDMC_CAS && nxt.st == PDMC_PRE && !r.we_n) begin
      nxt.force_bad = 1'b0; // one bad write per port write
    end
    if (r.st == PDMC_CAS && nxt.st == PDMC_PRE && r.we_n && (^r.q_s2)) begin
      nxt.nmi = 1'b1;
      nxt.irq = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      r <= '{st: PDMC_IDLE, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, default: '0};
    end else begin
      r <= nxt;
    end
  end

  assign ack_o = r.ack;
  assign rdata_o = r.rdata;
  assign nmi_n_o = ~r.nmi;
  assign nmi_vector_o = NMI_VECTOR;
  assign host_irq_o = r.irq;
  assign dram_addr_o = r.addr;
  assign dram_ras_n_o = r.ras_n;
  assign dram_cas_n_o = r.cas_n;
  assign dram_we_n_o = r.we_n;
  assign dram_d_o = r.dout;
  assign prom_addr_o = addr_i[10:0];
  assign prom_ce_n_o = (r.st != PDMC_PROM);
endmodule : pdmc_ctrl

// ### dv/pdmc_ctrl_sva.sv
// pdmc_ctrl_sva: strobe timing, decode and error flag checks.
// assumes binding to pdmc_ctrl; sees its ports only.
`timescale 1ns/1ps
module pdmc_ctrl_sva
  import pdmc_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic [15:0] addr_i,
  input wire logic ack_o,
  input wire logic nmi_n_o,
  input wire logic host_irq_o,
  input wire logic [ROW_BITS-1:0] dram_addr_o,
  input wire logic dram_ras_n_o,
  input wire logic dram_cas_n_o,
  input wire logic prom_ce_n_o
);
  logic ras_q_r;
  logic [5:0] lvl_r;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  // samples at the present ras level; reset value saturated so idle counts as precharged
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ras_q_r <= 1'b1;
      lvl_r <= 6'h3f;
    end else begin
      ras_q_r <= dram_ras_n_o;
      lvl_r <= (dram_ras_n_o != ras_q_r) ? 6'h01 : lvl_r + {5'h00, lvl_r != 6'h3f};
    end
  end
  a_prom_no_ras: assert property (!prom_ce_n_o |-> dram_ras_n_o && addr_i < PROM_TOP_ADDR)
    else $error("prom select with ras or high address");
  // the fall is seen one edge late, so four stable samples cover five held cycles
  a_row_hold: assert property ($fell(dram_ras_n_o) |=> $stable(dram_addr_o) [*4])
    else $error("row index moved too early");
  a_cas_window: assert property ($fell(dram_cas_n_o) |-> !dram_ras_n_o && lvl_r >= ROW_HOLD_CYC
    && lvl_r <= RAS_CAS_MAX_CYC)
    else $error("column strobe outside window");
  a_col_hold: assert property ($fell(dram_cas_n_o) |=> ($stable(dram_addr_o) && !dram_cas_n_o) [*8])
    else $error("column index not held");
  a_cas_in_ras: assert property (!dram_cas_n_o |-> !dram_ras_n_o)
    else $error("column strobe without row strobe");
  a_precharge_gap: assert property ($fell(dram_ras_n_o) |-> lvl_r >= PRECHARGE_CYC)
    else $error("precharge too short");
  a_ack_ends_row: assert property (ack_o && addr_i >= PROM_TOP_ADDR |-> $rose(dram_ras_n_o))
    else $error("dram ack without row close");
  a_nmi_with_irq: assert property ($fell(nmi_n_o) |-> host_irq_o)
    else $error("nmi without host interrupt");
endmodule : pdmc_ctrl_sva
bind pdmc_ctrl pdmc_ctrl_sva u_sva (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .addr_i(addr_i),
  .ack_o(ack_o), .nmi_n_o(nmi_n_o), .host_irq_o(host_irq_o), .dram_addr_o(dram_addr_o),
  .dram_ras_n_o(dram_ras_n_o), .dram_cas_n_o(dram_cas_n_o), .prom_ce_n_o(prom_ce_n_o));

// ### dv/pdmc_mem_model.sv
// pdmc_mem_model: nine 16Kx1 dram chips and a 2Kx8 prom.
// assumes early write: write strobe low before the column strobe falls.
`timescale 1ns/1ps
module pdmc_mem_model (
  input wire logic clk_i,
  input wire logic [6:0] a_i,
  input wire logic ras_n_i,
  input wire logic cas_n_i,
  input wire logic we_n_i,
  input wire logic [8:0] d_i,
  output logic [8:0] q_o,
  input wire logic [10:0] pa_i,
  input wire logic pce_n_i,
  output logic [7:0] pq_o
);
  logic [8:0] mem [16384];
  logic [6:0] row;
  logic [6:0] col;
  logic tgl = 1'b0;
  always @(posedge clk_i) tgl <= !tgl;
  always @(negedge ras_n_i) row = a_i;
  always @(negedge cas_n_i) begin
    col = a_i;
    if (!we_n_i) mem[{col, row}] = d_i;
  end
  // released outputs churn so a late sample cannot match by luck
  assign q_o = (cas_n_i || ras_n_i) ? {9{tgl}} : mem[{col, row}];
  assign pq_o = pce_n_i ? {8{tgl}} : pa_i[7:0] ^ {5'h00, pa_i[10:8]};
endmodule : pdmc_mem_model

// ### dv/tb.sv
// tb: random and corner accesses, forced bad parity, refresh.
// assumes the memory model on the far side of the controller.
`timescale 1ns/1ps
module tb;
  import pdmc_pkg::*;
  logic clk, nrst, req, we, ack, iow, nack, nmi_n, irq, clr, ras_n, cas_n, we_n, pce_n;
  logic [15:0] addr, vec, a;
  logic [7:0] wd, rd, port, iod, pq, d;
  logic [6:0] da;
  logic [8:0] dd, dq;
  logic [10:0] pa;
  int miscompares = 0;
  int compares = 0;
  int falls = 0;
  int k;
  pdmc_ctrl dut (.core_clk_i(clk), .nrst_i(nrst), .req_i(req), .we_i(we), .addr_i(addr),
    .wdata_i(wd), .ack_o(ack), .rdata_o(rd), .io_wr_i(iow), .io_port_i(port), .io_wdata_i(iod),
    .nmi_ack_i(nack), .nmi_n_o(nmi_n), .nmi_vector_o(vec), .host_irq_o(irq),
    .host_irq_clr_i(clr), .dram_addr_o(da), .dram_ras_n_o(ras_n), .dram_cas_n_o(cas_n),
    .dram_we_n_o(we_n), .dram_d_o(dd), .dram_q_i(dq), .prom_addr_o(pa), .prom_ce_n_o(pce_n),
    .prom_q_i(pq));
  pdmc_mem_model u_mem (.clk_i(clk), .a_i(da), .ras_n_i(ras_n), .cas_n_i(cas_n), .we_n_i(we_n),
    .d_i(dd), .q_o(dq), .pa_i(pa), .pce_n_i(pce_n), .pq_o(pq));
  initial begin
    clk = 1'b0;
    forever #2 clk = !clk;
  end
  always @(negedge ras_n) falls++;
  task complete_run;
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task acc(input logic w, input logic [15:0] ad, input logic [7:0] wv);
    int n;
    n = 0;
    @(posedge clk);
    req <= 1'b1;
    we <= w;
    addr <= ad;
    wd <= wv;
    do begin
      @(negedge clk);
      n++;
    end while (ack !== 1'b1 && n < 300);
    if (n >= 300) begin
      miscompares++;
      complete_run;
    end
    @(posedge clk);
    req <= 1'b0;
    // next request only after precharge has run out
    repeat (PRECHARGE_CYC + 1) @(posedge clk);
  endtask : acc
  task io(input logic [7:0] p);
    @(posedge clk);
    iow <= 1'b1;
    port <= p;
    iod <= 8'($urandom);
    @(posedge clk);
    iow <= 1'b0;
  endtask : io
  initial begin
    {nrst, req, we, iow, nack, clr, addr, wd, port, iod} = '0;
    k = $urandom(32'hfc535390);
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    for (k = 0; k < 14; k++) begin
      a = (k == 0) ? 16'h0800 : (k == 1) ? 16'hffff : 16'h0800 + 16'($urandom % 63488);
      d = 8'($urandom);
      acc(1'b1, a, d);
      acc(1'b0, a, 8'h00);
      chk({8'h00, rd}, {8'h00, d});
      chk({7'h00, u_mem.mem[a[13:0]]}, {7'h00, ^d, d});
      chk({15'h0000, nmi_n}, 16'h0001);
    end
    for (k = 0; k < 4; k++) begin
      a = (k == 0) ? 16'h0000 : (k == 1) ? 16'h07ff : {5'h00, 11'($urandom)};
      acc(1'b0, a, 8'h00);
      chk({8'h00, rd}, {8'h00, a[7:0] ^ {5'h00, a[10:8]}});
    end
    io(8'h70);
    acc(1'b1, 16'h1234, 8'h03);
    acc(1'b0, 16'h1234, 8'h00);
    chk({15'h0000, nmi_n}, 16'h0001);
    io(8'h71);
    acc(1'b1, 16'h1234, 8'h03);
    chk({7'h00, u_mem.mem[14'h1234]}, 16'h0103);
    acc(1'b0, 16'h1234, 8'h00);
    chk({14'h0000, nmi_n, irq}, 16'h0001);
    chk(vec, NMI_VECTOR);
    @(posedge clk);
    nack <= 1'b1;
    clr <= 1'b1;
    @(posedge clk);
    nack <= 1'b0;
    clr <= 1'b0;
    @(negedge clk);
    chk({14'h0000, nmi_n, irq}, 16'h0002);
    k = falls;
    repeat (REFRESH_CYC + 100) @(posedge clk);
    chk({15'h0000, falls > k}, 16'h0001);
    complete_run;
  end
endmodule : tb
